/* hdl/apf_framer.sv */
// Framed-unit adaptation between a TCP byte stream and a placement engine, with startup control.
// Assumes TCP engine, upper layer and placement engine all run on clk; byte-wide handshakes.
`timescale 1ns/1ps
module apf_framer
	import apf_pkg::*;
#(
	parameter int RESP_WAIT = RESP_WAIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic cfgInitiator,
	input wire logic cfgCrcOn,
	input wire logic cfgMarkersOn,
	input wire logic startFraming,
	input wire logic stopFraming,
	input wire logic enterFullOp,
	input wire logic placementBound,
	input wire logic emssValid,
	input wire logic [15:0] effectiveSegmentSize,
	input wire logic [15:0] linkMtu,
	input wire logic [15:0] hdrBytes,
	output logic [15:0] maxPayloadSize,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	output logic rxReady,
	output logic suRxValid,
	output logic [7:0] suRxData,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txFirst,
	input wire logic [15:0] txUnitLen,
	output logic txReady,
	output logic tcpTxValid,
	output logic [7:0] tcpTxData,
	output logic tcpTxSegStart,
	input wire logic tcpTxReady,
	output logic plValid,
	output logic [7:0] plData,
	output logic plLast,
	input wire logic plReady,
	output logic phaseStartup,
	output logic phaseFull,
	output logic errRole,
	output logic errBind,
	output logic errCrc,
	output logic errLength,
	output logic markerMismatch,
	output logic huntActive
);
	apf_size_if sz();
	assign sz.emssValid = emssValid;
	assign sz.effectiveSegmentSize = effectiveSegmentSize;
	assign sz.linkMtu = linkMtu;
	assign sz.hdrBytes = hdrBytes;
	assign sz.markersOn = cfgMarkersOn;
	apf_size_calc u_size (
		.clk(clk),
		.srst(srst),
		.sz(sz.calc)
	);
	assign maxPayloadSize = sz.maxPayloadSize;

	// Phase control
	apf_phase_t phase_ff, nxt_phase;
	logic [3:0] suIdx_ff;
	logic [31:0] waitCnt_ff;
	logic errRole_ff, errBind_ff;
	logic suRxValid_ff;
	logic [7:0] suRxData_ff;

	wire inStartup = (phase_ff == PH_STARTUP);
	wire inFull = (phase_ff == PH_FULL);
	wire rxFire = rxValid && rxReady;
	wire keyByte = inStartup && rxFire && (suIdx_ff == KEY_DIFF_IDX);
	// Initiator must see a reply; a request back means both sides started as initiator
	wire sameRoleKey = keyByte && (cfgInitiator ? (rxData == KEY_REQ_BYTE)
		: (rxData == KEY_REP_BYTE));
	// Responder with nothing arriving: the peer is likely a responder too
	wire respTimeout = inStartup && !cfgInitiator && (suIdx_ff == 4'h0)
		&& (waitCnt_ff == 32'(RESP_WAIT));
	wire roleClash = sameRoleKey || respTimeout;
	wire goFull = inStartup && enterFullOp && placementBound && !roleClash;
	wire badBind = inStartup && enterFullOp && !placementBound;

	always_comb begin
		nxt_phase = phase_ff;
		unique case (phase_ff)
			PH_IDLE: if (startFraming) nxt_phase = PH_STARTUP;
			PH_STARTUP: begin
				if (roleClash || badBind) begin
					nxt_phase = PH_FAIL;
				end else if (goFull) begin
					nxt_phase = PH_FULL;
				end
			end
			PH_FULL: if (stopFraming) nxt_phase = PH_IDLE;
			PH_FAIL: if (stopFraming) nxt_phase = PH_IDLE;
		endcase
	end

	wire enterFull = (nxt_phase == PH_FULL) && !inFull;

	always_ff @(posedge clk) begin
		if (srst) begin
			phase_ff <= PH_IDLE;
			suIdx_ff <= 4'h0;
			waitCnt_ff <= 32'h00000000;
			errRole_ff <= 1'b0;
			errBind_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			if (!inStartup) begin
				suIdx_ff <= 4'h0;
				waitCnt_ff <= 32'h00000000;
			end else begin
				if (rxFire && suIdx_ff <= KEY_DIFF_IDX) suIdx_ff <= 4'(suIdx_ff + 4'h1);
				if (waitCnt_ff != 32'(RESP_WAIT)) waitCnt_ff <= 32'(waitCnt_ff + 32'h1);
			end
			if (startFraming && phase_ff == PH_IDLE) begin
				errRole_ff <= 1'b0;
				errBind_ff <= 1'b0;
			end else begin
				if (inStartup && roleClash) errRole_ff <= 1'b1;
				if (badBind) errBind_ff <= 1'b1;
			end
		end
	end

	// Startup bytes go to the upper layer untouched
	always_ff @(posedge clk) begin
		if (srst) begin
			suRxValid_ff <= 1'b0;
			suRxData_ff <= 8'h00;
		end else begin
			suRxValid_ff <= inStartup && rxFire;
			if (inStartup && rxFire) suRxData_ff <= rxData;
		end
	end

	// Transmit path: one output register, optional leading zero marker
	logic tcpTxValid_ff, tcpTxSegStart_ff;
	logic [7:0] tcpTxData_ff;
	logic firstPend_ff;
	logic [2:0] mkrLeft_ff;
	logic [15:0] segRoom_ff;

	wire txActive = inStartup || inFull;
	wire outFree = !tcpTxValid_ff || tcpTxReady;
	wire insertMkr = inFull && firstPend_ff && cfgMarkersOn && txValid;
	assign txReady = txActive && outFree && !insertMkr;
	wire txFire = txValid && txReady;
	wire frameStart = inFull && txFire && txFirst;
	// Pack a frame into the current segment only if it fits the room left
	wire needBreak = frameStart && (txUnitLen > segRoom_ff);
	wire [15:0] roomAfter = needBreak
		? ((sz.effSeg > txUnitLen) ? 16'(sz.effSeg - txUnitLen) : 16'h0000)
		: 16'(segRoom_ff - txUnitLen);

	always_ff @(posedge clk) begin
		if (srst) begin
			tcpTxValid_ff <= 1'b0;
			tcpTxData_ff <= 8'h00;
			tcpTxSegStart_ff <= 1'b0;
			firstPend_ff <= 1'b0;
			mkrLeft_ff <= 3'h0;
			segRoom_ff <= 16'h0000;
		end else begin
			if (enterFull) begin
				firstPend_ff <= 1'b1;
				mkrLeft_ff <= MARKER_BYTES;
				segRoom_ff <= 16'h0000;
			end else if (insertMkr && outFree) begin
				mkrLeft_ff <= 3'(mkrLeft_ff - 3'h1);
				if (mkrLeft_ff == 3'h1) firstPend_ff <= 1'b0;
			end else if (txFire && inFull) begin
				firstPend_ff <= 1'b0;
			end
			if (frameStart) segRoom_ff <= roomAfter;
			if (outFree) begin
				tcpTxValid_ff <= insertMkr || txFire;
				tcpTxSegStart_ff <= insertMkr ? (mkrLeft_ff == MARKER_BYTES) : needBreak;
				if (insertMkr) begin
					tcpTxData_ff <= MARKER_FIRST_BYTE;
				end else if (txFire) begin
					tcpTxData_ff <= txData;
				end
			end
		end
	end
	assign tcpTxValid = tcpTxValid_ff;
	assign tcpTxData = tcpTxData_ff;
	assign tcpTxSegStart = tcpTxSegStart_ff;

	// Receive path in full operation
	apf_rx_t rxSt_ff;
	logic [8:0] pos_ff;
	logic [15:0] since_ff, expPtr_ff;
	logic [7:0] mkrHi_ff, lenHi_ff;
	logic [15:0] len_ff, bodyLen_ff, idx_ff;
	logic [23:0] crcRx_ff;
	logic [1:0] crcIdx_ff;
	logic [31:0] crc_ff;
	logic [BUF_AW-1:0] rdPtr_ff;
	logic [7:0] buf_mem [0:(1 << BUF_AW)-1];
	logic plValid_ff, plLast_ff, errCrc_ff, errLen_ff, mkrMis_ff;
	logic [7:0] plData_ff;

	// Receive stalls only in idle, in fail, and while a verified frame drains
	assign rxReady = inStartup || (inFull && rxSt_ff != RX_DRAIN);
	wire fullFire = inFull && rxFire;
	wire isMkr = cfgMarkersOn && (pos_ff <= MARKER_LAST_POS);
	wire mkrDone = fullFire && isMkr && (pos_ff == MARKER_LAST_POS);
	wire [15:0] mkrPtr = {mkrHi_ff, rxData};
	wire dataByte = fullFire && !isMkr;
	wire [15:0] rxLen = {lenHi_ff, rxData};
	wire [1:0] padLen = 2'(2'h2 - rxData[1:0]);
	wire [15:0] rxBodyLen = 16'(rxLen + {14'h0000, padLen});
	wire lenTooBig = rxLen > BUF_MAX_LEN;
	wire [31:0] crcRecv = {crcRx_ff, rxData};
	// With CRC checking off, the CRC field always counts as valid
	wire crcGood = !cfgCrcOn || (crcRecv == ~crc_ff);
	wire crcLast = dataByte && rxSt_ff == RX_CRC && crcIdx_ff == CRC_LAST_IDX;
	wire crcByteIn = fullFire && (rxSt_ff == RX_LEN0 || rxSt_ff == RX_LEN1
		|| rxSt_ff == RX_BODY);
	wire plFree = !plValid_ff || plReady;
	wire drainFire = inFull && rxSt_ff == RX_DRAIN && plFree;
	wire drainEnd = drainFire && (16'(rdPtr_ff) == 16'(len_ff - 16'h1));

	always_ff @(posedge clk) begin
		if (srst) begin
			rxSt_ff <= RX_LEN0;
			pos_ff <= 9'h000;
			since_ff <= 16'h0000;
			expPtr_ff <= 16'h0000;
			mkrHi_ff <= 8'h00;
			lenHi_ff <= 8'h00;
			len_ff <= 16'h0000;
			bodyLen_ff <= 16'h0000;
			idx_ff <= 16'h0000;
			crcRx_ff <= 24'h000000;
			crcIdx_ff <= 2'h0;
			crc_ff <= CRC_INIT;
			rdPtr_ff <= '0;
			errCrc_ff <= 1'b0;
			errLen_ff <= 1'b0;
			mkrMis_ff <= 1'b0;
		end else if (enterFull) begin
			rxSt_ff <= RX_LEN0;
			pos_ff <= 9'h000;
			since_ff <= 16'h0000;
			crc_ff <= CRC_INIT;
			errCrc_ff <= 1'b0;
			errLen_ff <= 1'b0;
			mkrMis_ff <= 1'b0;
		end else begin
			errCrc_ff <= 1'b0;
			errLen_ff <= 1'b0;
			mkrMis_ff <= 1'b0;
			if (fullFire) begin
				pos_ff <= 9'(pos_ff + 9'h001);
				since_ff <= (rxSt_ff == RX_LEN0 && !isMkr) ? 16'h0001 : 16'(since_ff + 16'h1);
			end
			if (crcByteIn) crc_ff <= apf_crc_byte(crc_ff, rxData);
			if (fullFire && isMkr && pos_ff == 9'h000) begin
				expPtr_ff <= (rxSt_ff == RX_LEN0) ? 16'h0000 : since_ff;
			end
			if (fullFire && isMkr && pos_ff == 9'h002) mkrHi_ff <= rxData;
			// Marker only cross-checks the boundary found by length
			if (mkrDone && rxSt_ff != RX_HUNT && mkrPtr != expPtr_ff) begin
				mkrMis_ff <= 1'b1;
			end
			unique case (rxSt_ff)
				RX_LEN0: if (dataByte) begin
					lenHi_ff <= rxData;
					rxSt_ff <= RX_LEN1;
				end
				RX_LEN1: if (dataByte) begin
					len_ff <= rxLen;
					bodyLen_ff <= rxBodyLen;
					idx_ff <= 16'h0000;
					crcIdx_ff <= 2'h0;
					if (lenTooBig) begin
						errLen_ff <= 1'b1;
						rxSt_ff <= RX_HUNT;
					end else begin
						rxSt_ff <= (rxBodyLen == 16'h0000) ? RX_CRC : RX_BODY;
					end
				end
				RX_BODY: if (dataByte) begin
					if (idx_ff < len_ff) buf_mem[BUF_AW'(idx_ff)] <= rxData;
					idx_ff <= 16'(idx_ff + 16'h1);
					if (idx_ff == 16'(bodyLen_ff - 16'h1)) rxSt_ff <= RX_CRC;
				end
				RX_CRC: if (dataByte) begin
					crcRx_ff <= {crcRx_ff[15:0], rxData};
					crcIdx_ff <= 2'(crcIdx_ff + 2'h1);
					if (crcLast) begin
						crc_ff <= CRC_INIT;
						rdPtr_ff <= '0;
						if (!crcGood) begin
							errCrc_ff <= 1'b1;
							rxSt_ff <= RX_HUNT;
						end else begin
							rxSt_ff <= (len_ff == 16'h0000) ? RX_LEN0 : RX_DRAIN;
						end
					end
				end
				RX_DRAIN: if (drainFire) begin
					rdPtr_ff <= BUF_AW'(rdPtr_ff + 1'b1);
					if (drainEnd) rxSt_ff <= RX_LEN0;
				end
				RX_HUNT: begin
					crc_ff <= CRC_INIT;
					// Pointer of zero says a frame starts right after this marker
					if (mkrDone && mkrPtr == 16'h0000) rxSt_ff <= RX_LEN0;
				end
			endcase
		end
	end

	// Placement output; only complete frames reach here, CRC-verified while cfgCrcOn is set
	always_ff @(posedge clk) begin
		if (srst) begin
			plValid_ff <= 1'b0;
			plData_ff <= 8'h00;
			plLast_ff <= 1'b0;
		end else if (plFree) begin
			plValid_ff <= drainFire;
			plLast_ff <= drainEnd;
			if (drainFire) plData_ff <= buf_mem[rdPtr_ff];
		end
	end

	assign suRxValid = suRxValid_ff;
	assign suRxData = suRxData_ff;
	assign plValid = plValid_ff;
	assign plData = plData_ff;
	assign plLast = plLast_ff;
	assign phaseStartup = inStartup;
	assign phaseFull = inFull;
	assign errRole = errRole_ff;
	assign errBind = errBind_ff;
	assign errCrc = errCrc_ff;
	assign errLength = errLen_ff;
	assign markerMismatch = mkrMis_ff;
	assign huntActive = inFull && rxSt_ff == RX_HUNT;
endmodule : apf_framer

/* hdl/apf_pkg.sv */
// Constants, types and the CRC step function for the framed-unit adaptation block.
// Assumes one 100 MHz clock and byte-wide streams on every side.
package apf_pkg;
	localparam int CLK_MHZ = 100;
	localparam int RESP_WAIT_MS = 10;
	localparam int RESP_WAIT_CYC = RESP_WAIT_MS * 1000 * CLK_MHZ;
	localparam logic [15:0] FRAME_OVH = 16'h0006;
	localparam logic [15:0] MIN_PAYLOAD = 16'h0080;
	localparam int MARKER_SPAN_LOG2 = 9;
	localparam logic [8:0] MARKER_LAST_POS = 9'h003;
	localparam logic [7:0] MARKER_FIRST_BYTE = 8'h00;
	localparam logic [2:0] MARKER_BYTES = 3'h4;
	localparam logic [3:0] KEY_DIFF_IDX = 4'hb;
	localparam logic [7:0] KEY_REQ_BYTE = 8'h71;
	localparam logic [7:0] KEY_REP_BYTE = 8'h70;
	localparam logic [31:0] CRC_POLY = 32'h82f63b78;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam int BUF_AW = 11;
	localparam logic [15:0] BUF_MAX_LEN = 16'h0800;
	localparam logic [1:0] CRC_LAST_IDX = 2'h3;

	typedef enum logic [1:0] {PH_IDLE, PH_STARTUP, PH_FULL, PH_FAIL} apf_phase_t;
	typedef enum logic [2:0] {RX_LEN0, RX_LEN1, RX_BODY, RX_CRC, RX_DRAIN, RX_HUNT} apf_rx_t;

	// Reflected CRC32c, one byte per call
	function automatic logic [31:0] apf_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : apf_crc_byte
endpackage : apf_pkg

/* hdl/apf_size_if.sv */
// Interface carrying segment-size inputs to the payload sizer and its results back.
// Assumes the framer drives the inputs and the sizer registers the outputs.
`timescale 1ns/1ps
interface apf_size_if;
	logic emssValid;
	logic [15:0] effectiveSegmentSize;
	logic [15:0] linkMtu;
	logic [15:0] hdrBytes;
	logic markersOn;
	logic [15:0] effSeg;
	logic [15:0] maxPayloadSize;
	modport calc (
		input emssValid,
		input effectiveSegmentSize,
		input linkMtu,
		input hdrBytes,
		input markersOn,
		output effSeg,
		output maxPayloadSize
	);
	modport user (
		output emssValid,
		output effectiveSegmentSize,
		output linkMtu,
		output hdrBytes,
		output markersOn,
		input effSeg,
		input maxPayloadSize
	);
endinterface : apf_size_if

/* hdl/apf_size_calc.sv */
// Largest upper-layer payload that fits one segment, raised to MIN_PAYLOAD for tiny segments, registered.
// Assumes segment size and MTU inputs are steady for a few cycles when they change.
`timescale 1ns/1ps
module apf_size_calc
	import apf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	apf_size_if.calc sz
);
	logic [15:0] effSeg_ff;
	logic [15:0] mps_ff;
	wire [15:0] mtuSeg = (sz.linkMtu > sz.hdrBytes) ? 16'(sz.linkMtu - sz.hdrBytes) : 16'h0000;
	wire [15:0] seg = sz.emssValid ? sz.effectiveSegmentSize : mtuSeg;
	wire [15:0] spans = 16'(seg[15:MARKER_SPAN_LOG2]) + 16'(|seg[MARKER_SPAN_LOG2-1:0]);
	wire [15:0] markerRoom = sz.markersOn ? 16'(spans << 2) : 16'h0000;
	wire [15:0] ovh = 16'(FRAME_OVH + markerRoom + {14'h0000, seg[1:0]});
	wire [15:0] raw = (seg > ovh) ? 16'(seg - ovh) : 16'h0000;
	// Tiny segments still get a usable payload size
	wire [15:0] mps = (raw < MIN_PAYLOAD) ? MIN_PAYLOAD : raw;

	always_ff @(posedge clk) begin
		if (srst) begin
			effSeg_ff <= 16'h0000;
			mps_ff <= MIN_PAYLOAD;
		end else begin
			effSeg_ff <= seg;
			mps_ff <= mps;
		end
	end

	assign sz.effSeg = effSeg_ff;
	assign sz.maxPayloadSize = mps_ff;
endmodule : apf_size_calc

/* dv/apf_framer_assertions.sv */
// Port-level checks for apf_framer, bound to every instance.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module apf_framer_assertions
	import apf_pkg::*;
#(
	parameter int RESP_WAIT = RESP_WAIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic enterFullOp,
	input wire logic placementBound,
	input wire logic [15:0] maxPayloadSize,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxReady,
	input wire logic suRxValid,
	input wire logic [7:0] suRxData,
	input wire logic txReady,
	input wire logic tcpTxValid,
	input wire logic tcpTxReady,
	input wire logic plValid,
	input wire logic phaseStartup,
	input wire logic phaseFull,
	input wire logic errRole,
	input wire logic errBind,
	input wire logic errCrc,
	input wire logic huntActive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_rx_gate;
		rxReady |-> phaseStartup || phaseFull;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx open while idle");
	property p_tx_gate;
		txReady |-> (phaseStartup || phaseFull) && (!tcpTxValid || tcpTxReady);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx open while idle");
	property p_su_echo;
		suRxValid |-> $past(rxValid && rxReady && phaseStartup) && suRxData == $past(rxData);
	endproperty
	a_su_echo: assert property (p_su_echo) else $error("startup byte altered");
	property p_crc_hunt;
		errCrc |-> ##[0:1] huntActive;
	endproperty
	a_crc_hunt: assert property (p_crc_hunt) else $error("no hunt after bad check");
	property p_full_entry;
		$rose(phaseFull) |-> $past(enterFullOp && placementBound && phaseStartup);
	endproperty
	a_full_entry: assert property (p_full_entry) else $error("full entry uncommanded");
	property p_bind_err;
		$rose(errBind) |-> $past(enterFullOp && !placementBound) && !phaseFull;
	endproperty
	a_bind_err: assert property (p_bind_err) else $error("bind error misplaced");
	property p_role_err;
		$rose(errRole) |-> !phaseStartup && !phaseFull;
	endproperty
	a_role_err: assert property (p_role_err) else $error("role clash not rejected");
	property p_min_size;
		maxPayloadSize >= MIN_PAYLOAD;
	endproperty
	a_min_size: assert property (p_min_size) else $error("payload size too small");
	c_full: cover property ($rose(phaseFull));
	c_pl: cover property (plValid);
	c_role: cover property ($rose(errRole));
endmodule : apf_framer_assertions

bind apf_framer apf_framer_assertions #(.RESP_WAIT(RESP_WAIT)) i_apf_framer_assertions (
	.clk(clk), .srst(srst), .enterFullOp(enterFullOp), .placementBound(placementBound),
	.maxPayloadSize(maxPayloadSize), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
	.suRxValid(suRxValid), .suRxData(suRxData), .txReady(txReady), .tcpTxValid(tcpTxValid),
	.tcpTxReady(tcpTxReady), .plValid(plValid), .phaseStartup(phaseStartup),
	.phaseFull(phaseFull), .errRole(errRole), .errBind(errBind), .errCrc(errCrc),
	.huntActive(huntActive)
);

/* dv/apf_peer_model.sv */
// Remote peer: feeds the ordered receive stream, drains the transmit stream.
// Assumes the bench loads bytes through push and reads captures from got.
`timescale 1ns/1ps
module apf_peer_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic slow,
	input wire logic rxReady,
	output logic rxValid,
	output logic [7:0] rxData,
	input wire logic tcpTxValid,
	input wire logic [7:0] tcpTxData,
	input wire logic tcpTxSegStart,
	output logic tcpTxReady
);
	logic [7:0] q[$];
	logic [8:0] got[$];
	logic taken = 1'b0;
	initial begin
		rxValid = 1'b0;
		rxData = 8'h00;
		tcpTxReady = 1'b0;
	end
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask : push
	always @(posedge clk) begin
		taken = rxValid && rxReady;
		if (tcpTxValid && tcpTxReady) got.push_back({tcpTxSegStart, tcpTxData});
	end
	// Idle line shows inverted data, so a stale byte never looks fresh
	always @(negedge clk) begin
		tcpTxReady = !srst && (!slow || !tcpTxReady);
		if (taken || !rxValid) begin
			rxValid = q.size() > 0 && !srst;
			rxData = rxValid ? q.pop_front() : ~rxData;
		end
	end
endmodule : apf_peer_model

/* dv/apf_framer_tb.sv */
// Self-checking bench for apf_framer with the peer model on the TCP side.
// Assumes inputs move at falling edges; role wait shortened to 50 cycles.
`timescale 1ns/1ps
module apf_framer_tb
	import apf_pkg::*;
;
	logic clk, srst, cfgInitiator, cfgCrcOn, cfgMarkersOn, startFraming, stopFraming;
	logic enterFullOp, placementBound, emssValid, txValid, txFirst, plReady, slow;
	logic [15:0] effectiveSegmentSize, linkMtu, hdrBytes, txUnitLen, maxPayloadSize;
	logic [7:0] txData, rxData, suRxData, tcpTxData, plData;
	logic rxValid, rxReady, suRxValid, txReady, tcpTxValid, tcpTxSegStart, tcpTxReady;
	logic plValid, plLast, phaseStartup, phaseFull, errRole, errBind, errCrc, errLength;
	logic markerMismatch, huntActive;
	logic [7:0] suq[$];
	logic [8:0] plq[$];
	int errors = 0, samples_checked = 0, crcSeen = 0, oddSeen = 0;
	apf_framer #(.RESP_WAIT(50)) i_apf_framer (.clk(clk), .srst(srst),
		.cfgInitiator(cfgInitiator), .cfgCrcOn(cfgCrcOn), .cfgMarkersOn(cfgMarkersOn),
		.startFraming(startFraming), .stopFraming(stopFraming), .enterFullOp(enterFullOp),
		.placementBound(placementBound), .emssValid(emssValid), .linkMtu(linkMtu),
		.effectiveSegmentSize(effectiveSegmentSize), .hdrBytes(hdrBytes),
		.maxPayloadSize(maxPayloadSize), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .suRxValid(suRxValid), .suRxData(suRxData), .txValid(txValid),
		.txData(txData), .txFirst(txFirst), .txUnitLen(txUnitLen), .txReady(txReady),
		.tcpTxValid(tcpTxValid), .tcpTxData(tcpTxData), .tcpTxSegStart(tcpTxSegStart),
		.tcpTxReady(tcpTxReady), .plValid(plValid), .plData(plData), .plLast(plLast),
		.plReady(plReady), .phaseStartup(phaseStartup), .phaseFull(phaseFull),
		.errRole(errRole), .errBind(errBind), .errCrc(errCrc), .errLength(errLength),
		.markerMismatch(markerMismatch), .huntActive(huntActive));
	apf_peer_model i_apf_peer_model (.clk(clk), .srst(srst), .slow(slow), .rxReady(rxReady),
		.rxValid(rxValid), .rxData(rxData), .tcpTxValid(tcpTxValid), .tcpTxData(tcpTxData),
		.tcpTxSegStart(tcpTxSegStart), .tcpTxReady(tcpTxReady));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (suRxValid === 1'b1) suq.push_back(suRxData);
		if (plValid === 1'b1 && plReady === 1'b1) plq.push_back({plLast, plData});
		if (errCrc === 1'b1) crcSeen++;
		if (markerMismatch === 1'b1 || errLength === 1'b1) oddSeen++;
	end
	task automatic print_verdict();
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hold(input int n, input int want);
		chk(16'(n), 16'(want));
		if (n != want) print_verdict();
	endtask : hold
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Own checksum loop, so a slip in apf_crc_byte cannot hide
	function automatic logic [31:0] crcc(input logic [63:0] w, input int n);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = n - 1; i >= 0; i--) begin
			c = c ^ {24'h000000, w[8 * i +: 8]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crcc
	task automatic pushw(input logic [63:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) i_apf_peer_model.push(w[8 * i +: 8]);
	endtask : pushw
	task automatic keyed(input logic [7:0] key);
		for (int i = 0; i < 16; i++) i_apf_peer_model.push(i == 11 ? key : 8'(i));
	endtask : keyed
	task automatic start(input logic init);
		cfgInitiator = init;
		startFraming = 1'b1;
		cyc(1);
		startFraming = 1'b0;
		chk(16'(phaseStartup), 16'h0001);
	endtask : start
	task automatic stop();
		stopFraming = 1'b1;
		cyc(1);
		stopFraming = 1'b0;
	endtask : stop
	task automatic go_full();
		enterFullOp = 1'b1;
		cyc(1);
		enterFullOp = 1'b0;
	endtask : go_full
	task automatic size(input logic v, input logic [15:0] e, input logic m, input logic [15:0] x);
		emssValid = v;
		effectiveSegmentSize = e;
		cfgMarkersOn = m;
		cyc(4);
		chk(maxPayloadSize, x);
	endtask : size
	task automatic s_size();
		chk(maxPayloadSize, 16'h0080);
		chk(16'({rxReady, txReady}), 16'h0000);
		size(1'b1, 16'd1000, 1'b1, 16'h03da);
		size(1'b1, 16'd1002, 1'b0, 16'h03e2);
		size(1'b0, 16'd0, 1'b1, 16'h05a2);
		size(1'b1, 16'd100, 1'b1, 16'h0080);
		size(1'b1, 16'd1000, 1'b1, 16'h03da);
	endtask : s_size
	task automatic s_main();
		start(1'b1);
		keyed(KEY_REP_BYTE);
		for (int i = 0; i < 200 && suq.size() < 16; i++) cyc(1);
		hold(suq.size(), 16);
		for (int i = 0; i < 16; i++) chk(16'(suq[i]), i == 11 ? 16'(KEY_REP_BYTE) : 16'(i));
		chk(16'({rxReady, txReady}), 16'h0003);
		go_full();
		chk(16'({phaseFull, phaseStartup}), 16'h0002);
	endtask : s_main
	task automatic send(input logic [7:0] d, input logic first);
		int i;
		txValid = 1'b1;
		txData = d;
		txFirst = first;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (txReady === 1'b1) break;
		end
		hold(int'(i < 50), 1);
		cyc(1);
	endtask : send
	task automatic s_tx();
		logic [8:0] g[$];
		slow = 1'b1;
		txUnitLen = 16'h0004;
		for (int u = 0; u < 2; u++) for (int i = 0; i < 4; i++) send(8'(16 * u + i), i == 0);
		txValid = 1'b0;
		for (int i = 0; i < 100 && i_apf_peer_model.got.size() < 12; i++) cyc(1);
		g = i_apf_peer_model.got;
		hold(g.size(), 12);
		chk(16'(g[0]), 16'h0100);
		for (int k = 1; k < 4; k++) chk(16'(g[k]), 16'h0000);
		for (int k = 0; k < 8; k++) chk(16'(g[4 + k][7:0]), 16'(k / 4 * 16 + k % 4));
		chk(16'(g[8][8]), 16'h0000);
		slow = 1'b0;
	endtask : s_tx
	task automatic s_rx();
		logic [31:0] c;
		c = crcc(64'h0000_0000_0002_a55a, 8);
		pushw(64'h0000_0000_0002_a55a, 8);
		pushw(64'(c >> 8), 3);
		cyc(40);
		hold(plq.size(), 0);
		pushw(64'(c[7:0]), 1);
		for (int i = 0; i < 40 && plq.size() < 2; i++) cyc(1);
		hold(plq.size(), 2);
		chk(16'(plq[0]), 16'h00a5);
		chk(16'(plq[1]), 16'h015a);
		c = crcc(64'h0002_1122, 4) ^ 32'h00000001;
		pushw({32'h0002_1122, c}, 8);
		for (int i = 0; i < 60 && crcSeen == 0; i++) cyc(1);
		hold(crcSeen, 1);
		cyc(2);
		chk(16'(huntActive), 16'h0001);
		chk(16'(plq.size()), 16'h0002);
	endtask : s_rx
	// Fill up to the next marker slot, then regain sync and walk on by length
	task automatic s_hunt();
		for (int i = 20; i < 512; i++) i_apf_peer_model.push(8'hff);
		pushw(64'h0000_0000_0002_3c4d, 8);
		pushw(64'(crcc(64'h0002_3c4d, 4)), 4);
		for (int i = 0; i < 600 && plq.size() < 4; i++) cyc(1);
		hold(plq.size(), 4);
		chk(16'(plq[3]), 16'h014d);
		cfgCrcOn = 1'b0;
		pushw(64'h0002_6e7f_0000_0000, 8);
		for (int i = 0; i < 40 && plq.size() < 6; i++) cyc(1);
		hold(plq.size(), 6);
		chk(16'(plq[5]), 16'h017f);
		chk(16'(oddSeen), 16'h0000);
		cfgCrcOn = 1'b1;
	endtask : s_hunt
	task automatic s_bind();
		stop();
		start(1'b1);
		placementBound = 1'b0;
		go_full();
		chk(16'({errBind, phaseFull}), 16'h0002);
		stop();
		placementBound = 1'b1;
	endtask : s_bind
	task automatic s_clash();
		// Responder hearing nothing: the peer is taken to be a responder too
		start(1'b0);
		for (int i = 0; i < 100 && errRole !== 1'b1; i++) cyc(1);
		hold(int'(errRole === 1'b1), 1);
		chk(16'(phaseStartup), 16'h0000);
		stop();
		start(1'b1);
		chk(16'(errBind), 16'h0000);
		keyed(KEY_REQ_BYTE);
		for (int i = 0; i < 100 && errRole !== 1'b1; i++) cyc(1);
		hold(int'(errRole === 1'b1), 1);
		chk(16'({phaseStartup, rxReady, txReady}), 16'h0000);
	endtask : s_clash
	initial begin
		srst = 1'b1;
		{cfgInitiator, startFraming, stopFraming, enterFullOp, txValid, txFirst, slow} = '0;
		{txData, txUnitLen} = '0;
		{cfgCrcOn, placementBound, plReady, emssValid, cfgMarkersOn} = '1;
		effectiveSegmentSize = 16'd1000;
		linkMtu = 16'd1500;
		hdrBytes = 16'd40;
		cyc(5);
		srst = 1'b0;
		s_size();
		s_main();
		s_tx();
		s_rx();
		s_hunt();
		s_bind();
		s_clash();
		print_verdict();
	end
endmodule : apf_framer_tb
